// ==== ide_pkg.sv ====
// Package: encodings, phases, timing and reset values for the decoder core
package ide_pkg;
  // Phase cycles of one instruction cycle
  typedef enum logic [1:0] {IDE_Q1, IDE_Q2, IDE_Q3, IDE_Q4} ide_phase_t;

  // Timing
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          PHASES_PER_CYC  = 4;
  localparam logic [1:0]  PHASE_LAST      = 2'(PHASES_PER_CYC - 1);

  // Opcode patterns (upper bits; OPW_ patterns are whole words)
  localparam logic [5:0]  OP6_TABLE_WRITE = 6'h2b;  // 1010 11
  localparam logic [5:0]  OP6_LATCH_READ  = 6'h28;  // 1010 00
  localparam logic [5:0]  OP6_LATCH_WRITE = 6'h29;  // 1010 01
  localparam logic [6:0]  OP7_XOR_FILE    = 7'h06;  // 0000 110
  localparam logic [4:0]  OP5_SKIP_CLEAR  = 5'h13;  // 1001 1
  localparam logic [4:0]  OP5_SKIP_SET    = 5'h12;  // 1001 0
  localparam logic [2:0]  OP3_JUMP        = 3'h6;
  localparam logic [2:0]  OP3_CALL        = 3'h7;
  localparam logic [7:0]  OP8_CMP_EQ      = 8'h31;
  localparam logic [7:0]  OP8_CMP_GT      = 8'h32;
  localparam logic [7:0]  OP8_LIT_LOAD    = 8'hb0;
  localparam logic [7:0]  OP8_LIT_SUB     = 8'hb2;
  localparam logic [7:0]  OP8_XOR_LIT     = 8'hb4;
  localparam logic [7:0]  OP8_AND_LIT     = 8'hb5;
  localparam logic [7:0]  OP8_LIT_RETURN  = 8'hb6;
  localparam logic [7:0]  OP8_LONG_CALL   = 8'hb7;
  localparam logic [7:0]  OP8_BANK_LOW    = 8'hb8;
  localparam logic [6:0]  OP7_BANK_HIGH   = 7'h5d;  // 1011 101
  localparam logic [7:0]  OP8_LIT_MUL     = 8'hbc;
  localparam logic [15:0] OPW_RETURN      = 16'h0002;
  localparam logic [15:0] OPW_WDT_CLEAR   = 16'h0004;
  localparam logic [15:0] OPW_IRQ_RETURN  = 16'h0005;
  localparam logic [15:0] OPW_NOP         = 16'h0000;

  // Data file address of the program counter low byte
  localparam logic [7:0]  PC_LOW_ADDR     = 8'h02;

  // Status register bit positions
  localparam int          FLG_C           = 0;
  localparam int          FLG_DIGIT       = 1;
  localparam int          FLG_Z           = 2;
  localparam int          FLG_OVF         = 3;

  // Reset values and stack depth
  localparam logic [15:0] PC_RESET        = 16'h0000;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
  localparam logic [3:0]  FLAGS_RESET     = 4'h0;
  localparam logic [3:0]  STACK_PTR_RESET = 4'h0;
  localparam int          STACK_DEPTH     = 16;
endpackage

// ==== ide_phase_gen.sv ====
// Four-phase generator dividing the core clock by four
`timescale 1ns/1ns
module ide_phase_gen
  import ide_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Phase outputs
  output ide_pkg::ide_phase_t     phase,
  output logic                    cycle_end
);
  ide_phase_t next_phase;

  // Advance one phase per clock
  always_comb
  begin
    case (phase)
      IDE_Q1:  next_phase = IDE_Q2;
      IDE_Q2:  next_phase = IDE_Q3;
      IDE_Q3:  next_phase = IDE_Q4;
      IDE_Q4:  next_phase = IDE_Q1;
      default: next_phase = IDE_Q1;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      phase <= IDE_Q1;
    else
      phase <= next_phase;
  end

  // Last phase marks end of instruction cycle
  assign cycle_end = (phase == IDE_Q4);
endmodule

// ==== ide_alu.sv ====
// Literal and file ALU with flag generation
`timescale 1ns/1ns
module ide_alu
  import ide_pkg::*;
(
  // Operands
  input  wire logic [7:0]   opcode_hi,
  input  wire logic [7:0]   literal,
  input  wire logic [7:0]   file_data,
  input  wire logic [7:0]   working,
  input  wire logic [3:0]   flags_in,
  // Results
  output logic [7:0]        result,
  output logic [15:0]       product,
  output logic [3:0]        flags_out
);
  logic [8:0] diff;
  logic [4:0] low_diff;

  // Literal minus working value with borrow-style carries
  always_comb
  begin
    diff      = {1'b0, literal} + {1'b0, ~working} + 9'h001;
    low_diff  = {1'b0, literal[3:0]} + {1'b0, ~working[3:0]} + 5'h01;
    product   = 16'(literal) * 16'(working);
    flags_out = flags_in;
    result    = working;
    if (opcode_hi == OP8_XOR_LIT)
    begin
      result           = literal ^ working;
      flags_out[FLG_Z] = (result == 8'h00);
    end
    else if (opcode_hi == OP8_AND_LIT)
    begin
      result           = literal & working;
      flags_out[FLG_Z] = (result == 8'h00);
    end
    else if (opcode_hi == OP8_LIT_SUB)
    begin
      result               = diff[7:0];
      flags_out[FLG_C]     = diff[8];
      flags_out[FLG_DIGIT] = low_diff[4];
      flags_out[FLG_Z]     = (diff[7:0] == 8'h00);
      flags_out[FLG_OVF]   = (literal[7] != working[7]) &&
                             (diff[7] != literal[7]);
    end
    else if (opcode_hi[7:1] == OP7_XOR_FILE)
    begin
      result           = file_data ^ working;
      flags_out[FLG_Z] = (result == 8'h00);
    end
    else if (opcode_hi == OP8_LIT_LOAD || opcode_hi == OP8_LIT_RETURN)
    begin
      result = literal;
    end
  end
endmodule

// ==== ide_core.sv ====
// Instruction decode and execute sequencer for the 8-bit core
`timescale 1ns/1ns
module ide_core
  import ide_pkg::*;
#(
  parameter bit HAS_EXTENDED = 1'b1
)
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Program memory
  output logic [15:0]       prog_addr,
  input  wire logic [15:0]  prog_data,
  // Data register file
  output logic [7:0]        file_addr,
  input  wire logic [7:0]   file_rdata,
  output logic [7:0]        file_wdata,
  output logic              file_we,
  // Table write control
  input  wire logic         table_internal,
  input  wire logic         table_read_pcl,
  input  wire logic         irq_event,
  // State visible to the system
  output logic [7:0]        working_register,
  output logic [7:0]        bank_select_register,
  output logic [7:0]        pc_high_latch,
  output logic [3:0]        alu_flags,
  output logic [15:0]       product,
  output logic              timeout_status_bit,
  output logic              powerdown_status_bit,
  output logic              global_irq_disable_bit,
  output logic              skip_active,
  output logic [1:0]        phase_num
);
  // ----------------------------------------------------------------
  // Phase generator and ALU
  // ----------------------------------------------------------------
  ide_phase_t phase;
  logic       cycle_end;
  logic [7:0] alu_result;
  logic [15:0] alu_product;
  logic [3:0] alu_flags_out;
  logic [15:0] instr;
  logic [15:0] pc;
  logic [3:0]  stall;
  logic        nop_next;
  logic        tw_busy;
  logic [3:0]  sp;
  logic [15:0] stack [STACK_DEPTH];

  ide_phase_gen u_phase
  (
    .clk       (clk),
    .rst       (rst),
    .phase     (phase),
    .cycle_end (cycle_end)
  );

  ide_alu u_alu
  (
    .opcode_hi (instr[15:8]),
    .literal   (instr[7:0]),
    .file_data (file_rdata),
    .working   (working_register),
    .flags_in  (alu_flags),
    .result    (alu_result),
    .product   (alu_product),
    .flags_out (alu_flags_out)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic is_twrite, is_xorf, is_bclr, is_bset, is_jump, is_call;
  logic is_long_call_instr, is_blow, is_bhigh, is_mul, is_ret, is_iret;
  logic is_lret, is_wdt, is_ceq, is_cgt, is_lit_alu;
  logic skip_cond, bit_val, flow_two;

  always_comb
  begin
    is_twrite = (instr[15:10] == OP6_TABLE_WRITE);
    is_xorf   = (instr[15:9] == OP7_XOR_FILE);
    is_bclr   = (instr[15:11] == OP5_SKIP_CLEAR);
    is_bset   = (instr[15:11] == OP5_SKIP_SET);
    is_jump   = (instr[15:13] == OP3_JUMP);
    is_call   = (instr[15:13] == OP3_CALL);
    is_long_call_instr  = (instr[15:8] == OP8_LONG_CALL);
    is_blow   = (instr[15:8] == OP8_BANK_LOW);
    is_bhigh  = (instr[15:9] == OP7_BANK_HIGH) && HAS_EXTENDED;
    is_mul    = (instr[15:8] == OP8_LIT_MUL) && HAS_EXTENDED;
    is_ret    = (instr == OPW_RETURN);
    is_iret   = (instr == OPW_IRQ_RETURN);
    is_lret   = (instr[15:8] == OP8_LIT_RETURN);
    is_wdt    = (instr == OPW_WDT_CLEAR);
    is_ceq    = (instr[15:8] == OP8_CMP_EQ);
    is_cgt    = (instr[15:8] == OP8_CMP_GT);
    is_lit_alu = (instr[15:8] == OP8_LIT_LOAD) ||
                 (instr[15:8] == OP8_AND_LIT) ||
                 (instr[15:8] == OP8_XOR_LIT) ||
                 (instr[15:8] == OP8_LIT_SUB) || is_lret;
    // Bit picked by the three b bits of a bit test
    bit_val   = file_rdata[instr[10:8]];
    // Skip conditions from file data read in the read phase
    skip_cond = (is_bclr && !bit_val) ||
                (is_bset && bit_val) ||
                (is_ceq && file_rdata == working_register) ||
                (is_cgt && file_rdata > working_register);
    // Control flow that needs a second, forced no-op cycle
    flow_two  = is_jump || is_call || is_long_call_instr || is_ret || is_iret ||
                is_lret;
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  logic [15:0] next_pc, next_instr;
  logic [3:0]  next_stall, next_sp, next_alu_flags;
  logic        next_nop, next_skip, next_tw_busy;
  logic [7:0]  next_w, next_bank, next_latch;
  logic [15:0] next_product;
  logic        next_timeout, next_powerdown, next_gid;
  logic        push;
  logic [15:0] target;
  logic        live;

  // A cycle really executes unless it is a forced no-op or a stall
  assign live = !nop_next && (stall == 4'h0);

  always_comb
  begin
    next_pc        = pc;
    next_instr     = instr;
    next_stall     = stall;
    next_nop       = nop_next;
    next_skip      = skip_active;
    next_tw_busy   = tw_busy;
    next_sp        = sp;
    next_w         = working_register;
    next_bank      = bank_select_register;
    next_latch     = pc_high_latch;
    next_alu_flags = alu_flags;
    next_product   = product;
    next_timeout   = timeout_status_bit;
    next_powerdown = powerdown_status_bit;
    next_gid       = global_irq_disable_bit;
    push           = 1'b0;
    target         = pc;
    file_we        = 1'b0;
    file_wdata     = alu_result;
    // Q3 executes; Q4 writes; only a live, non-stall cycle acts
    if (phase == IDE_Q3 && live)
    begin
      if (is_lit_alu || is_xorf)
      begin
        if (!is_xorf || !instr[8])
        begin
          next_w = alu_result;
        end
        next_alu_flags = alu_flags_out;
      end
      if (is_mul)
      begin
        next_product = alu_product;
      end
      if (is_blow)
      begin
        next_bank[3:0] = instr[3:0];
      end
      if (is_bhigh)
      begin
        next_bank[7:4] = instr[7:4];
      end
      if (is_wdt)
      begin
        next_timeout   = 1'b1;
        next_powerdown = 1'b1;
      end
      if (is_iret)
      begin
        next_gid = 1'b0;
      end
    end
    if (phase == IDE_Q4 && live && is_xorf && instr[8])
    begin
      file_we = 1'b1;
    end
    // End of instruction cycle: fetch, skip and stall handling
    if (cycle_end)
    begin
      // Take the next word and step pc past it
      next_instr = prog_data;
      next_pc    = pc + 16'h0001;
      next_nop   = 1'b0;
      next_skip  = 1'b0;
      if (stall != 4'h0)
      begin
        next_instr = OPW_NOP;
        next_pc    = pc;
        next_nop   = 1'b1;
        next_stall = stall - 4'h1;
        // Internal table write holds until an interrupt event; the
        // write word is gone from instr by now, so a flag remembers it
        if (tw_busy && table_internal && !irq_event)
        begin
          next_stall = stall;
        end
        else
        begin
          next_tw_busy = 1'b0;
        end
      end
      else if (!nop_next)
      begin
        if (skip_cond)
        begin
          next_nop  = 1'b1;
          next_skip = 1'b1;
          next_instr = OPW_NOP;
        end
        else if (flow_two)
        begin
          next_nop   = 1'b1;
          next_instr = OPW_NOP;
          next_stall = table_read_pcl ? 4'h1 : 4'h0;
          // Jump and call keep the page bits of the current pc
          if (is_jump || is_call)
          begin
            target     = {pc[15:13], instr[12:0]};
            next_latch = target[15:8];
          end
          else if (is_long_call_instr)
          begin
            target = {pc_high_latch, instr[7:0]};
          end
          else
          begin
            // Returns pop the most recent entry
            target  = stack[sp - 4'h1];
            next_sp = sp - 4'h1;
          end
          // Calls push the return address
          if (is_call || is_long_call_instr)
          begin
            push    = 1'b1;
            next_sp = sp + 4'h1;
          end
          next_pc = target;
        end
        else if (is_twrite)
        begin
          // Hold pc so the word behind the write is fetched again
          next_nop     = 1'b1;
          next_instr   = OPW_NOP;
          next_pc      = pc;
          next_stall   = table_internal ? 4'h1 : 4'h0;
          next_tw_busy = table_internal;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pc                     <= PC_RESET;
      instr                  <= OPW_NOP;
      stall                  <= 4'h0;
      nop_next               <= 1'b1;
      skip_active            <= 1'b0;
      tw_busy                <= 1'b0;
      sp                     <= STACK_PTR_RESET;
      working_register       <= BYTE_RESET;
      bank_select_register   <= BYTE_RESET;
      pc_high_latch          <= BYTE_RESET;
      alu_flags              <= FLAGS_RESET;
      product                <= 16'h0000;
      timeout_status_bit     <= 1'b1;
      powerdown_status_bit   <= 1'b1;
      global_irq_disable_bit <= 1'b1;
    end
    else
    begin
      pc                     <= next_pc;
      instr                  <= next_instr;
      stall                  <= next_stall;
      nop_next               <= next_nop;
      skip_active            <= next_skip;
      tw_busy                <= next_tw_busy;
      sp                     <= next_sp;
      working_register       <= next_w;
      bank_select_register   <= next_bank;
      pc_high_latch          <= next_latch;
      alu_flags              <= next_alu_flags;
      product                <= next_product;
      timeout_status_bit     <= next_timeout;
      powerdown_status_bit   <= next_powerdown;
      global_irq_disable_bit <= next_gid;
    end
  end

  // Return stack storage
  always_ff @(posedge clk)
  begin
    if (push)
      stack[sp] <= pc;
  end

  // Memory addressing
  assign prog_addr = pc;
  assign file_addr = instr[7:0];
  assign phase_num = phase;
endmodule

// ==== ide_core_checker.sv ====
// Checker of phase order, write timing and skip behaviour of the core
`timescale 1ns/1ns
module ide_core_checker
  import ide_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // File write port
  input wire logic [7:0]  file_rdata,
  input wire logic [7:0]  file_wdata,
  input wire logic        file_we,
  // Core state
  input wire logic [7:0]  working_register,
  input wire logic [7:0]  bank_select_register,
  input wire logic [3:0]  alu_flags,
  input wire logic        timeout_status_bit,
  input wire logic        powerdown_status_bit,
  input wire logic        global_irq_disable_bit,
  input wire logic        skip_active,
  input wire logic [1:0]  phase_num
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  // Reset seen at the previous edge masks the release edge, where
  // sampled values still jump to their reset levels
  logic rst_seen;

  always_ff @(posedge clk)
  begin
    rst_seen <= rst;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || rst_seen);

  property p_phase_cycle;
    phase_num == 2'd0 |-> ##1 phase_num == 2'd1 ##1 phase_num == 2'd2
      ##1 phase_num == 2'd3 ##1 phase_num == 2'd0;
  endproperty
  a_phase_cycle: assert property (p_phase_cycle)
    else $error("phase order broken");

  property p_reset_state;
    disable iff (1'b0) rst |=> phase_num == 2'd0 && timeout_status_bit
      && powerdown_status_bit && global_irq_disable_bit;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset state wrong");

  property p_we_data;
    file_we |-> phase_num == 2'd3
      && file_wdata == (working_register ^ file_rdata);
  endproperty
  a_we_data: assert property (p_we_data)
    else $error("file write wrong");

  property p_we_pulse;
    file_we |=> !file_we;
  endproperty
  a_we_pulse: assert property (p_we_pulse)
    else $error("file write too long");

  property p_skip_rise;
    $rose(skip_active) |-> phase_num == 2'd0 ##0 skip_active [*4];
  endproperty
  a_skip_rise: assert property (p_skip_rise)
    else $error("forced nop not a whole cycle");

  property p_nop_quiet;
    skip_active && phase_num == 2'd3 |->
      $stable(working_register) && $stable(alu_flags);
  endproperty
  a_nop_quiet: assert property (p_nop_quiet)
    else $error("forced nop changed state");

  property p_w_moment;
    !$stable(working_register) |-> phase_num == 2'd3;
  endproperty
  a_w_moment: assert property (p_w_moment)
    else $error("working register off phase");

  property p_flag_moment;
    !$stable(alu_flags) |-> phase_num == 2'd3 && !skip_active;
  endproperty
  a_flag_moment: assert property (p_flag_moment)
    else $error("flags off phase");

  property p_bank_moment;
    !$stable(bank_select_register) |-> phase_num == 2'd3 && !skip_active;
  endproperty
  a_bank_moment: assert property (p_bank_moment)
    else $error("bank select off phase");

  c_skip: cover property ($rose(skip_active));
  c_we: cover property (file_we);
  c_bank: cover property (!$stable(bank_select_register));
endmodule

bind ide_core ide_core_checker i_chk (
  .clk(clk), .rst(rst), .file_rdata(file_rdata), .file_wdata(file_wdata),
  .file_we(file_we), .working_register(working_register),
  .bank_select_register(bank_select_register), .alu_flags(alu_flags),
  .timeout_status_bit(timeout_status_bit),
  .powerdown_status_bit(powerdown_status_bit),
  .global_irq_disable_bit(global_irq_disable_bit),
  .skip_active(skip_active), .phase_num(phase_num)
);

// ==== ide_core_tb.sv ====
// Self-checking bench for the decoder core
`timescale 1ns/1ns
module ide_core_tb;
  import ide_pkg::*;
  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [15:0] prog_data = 16'h0000;
  logic [7:0]  file_rdata = 8'h00;
  logic        table_internal = 1'b0;
  logic        table_read_pcl = 1'b0;
  logic        irq_event = 1'b0;
  logic [15:0] prog_addr;
  logic [7:0]  file_addr;
  logic [7:0]  file_wdata;
  logic        file_we;
  logic [7:0]  working_register;
  logic [7:0]  bank_select_register;
  logic [7:0]  pc_high_latch;
  logic [3:0]  alu_flags;
  logic [15:0] product;
  logic        timeout_status_bit;
  logic        powerdown_status_bit;
  logic        global_irq_disable_bit;
  logic        skip_active;
  logic [1:0]  phase_num;
  logic [15:0] mem [128];
  logic [7:0]  fmem [256];
  int          errors = 0;
  int          total_checks = 0;

  ide_core #(.HAS_EXTENDED(1'b1)) i_dut (
    .clk(clk), .rst(rst), .prog_addr(prog_addr), .prog_data(prog_data),
    .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we),
    .table_internal(table_internal), .table_read_pcl(table_read_pcl),
    .irq_event(irq_event), .working_register(working_register),
    .bank_select_register(bank_select_register),
    .pc_high_latch(pc_high_latch), .alu_flags(alu_flags),
    .product(product), .timeout_status_bit(timeout_status_bit),
    .powerdown_status_bit(powerdown_status_bit),
    .global_irq_disable_bit(global_irq_disable_bit),
    .skip_active(skip_active), .phase_num(phase_num)
  );

  // Core clock
  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  // Memories answer one clock after the address
  always @(posedge clk)
  begin
    prog_data  <= mem[prog_addr[6:0]];
    file_rdata <= fmem[file_addr];
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Advance to just after the execute edge of the next cycle
  task step(input int n);
    repeat (n)
    begin
      do
      begin
        @(posedge clk);
        #1;
      end
      while (phase_num !== 2'd3);
    end
  endtask

  task ex(input logic [7:0] w, input logic [3:0] f);
    step(1);
    check(16'(working_register), 16'(w));
    check(16'(alu_flags), 16'(f));
  endtask

  // Eight words, first word in the top bits
  task put(input logic [6:0] a, input logic [127:0] w);
    for (int i = 0; i < 8; i++)
      mem[a + 7'(i)] = w[127 - 16 * i -: 16];
  endtask

  task boot(input logic tin, input logic pc_low_byte);
    @(posedge clk);
    rst            <= 1'b1;
    table_internal <= tin;
    table_read_pcl <= pc_low_byte;
    irq_event      <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    step(1);
  endtask

  task stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_lit;
    put(0, {16'hb012, 16'hb4ff, 16'hb500, 16'hb005, 16'hb205, 16'hb203,
            16'hb280, 16'h0000});
    boot(1'b0, 1'b0);
    ex(8'h12, 4'h0);
    ex(8'hed, 4'h0);
    ex(8'h00, 4'h4);
    ex(8'h05, 4'h4);
    ex(8'h00, 4'h7);
    ex(8'h03, 4'h3);
    ex(8'h7d, 4'h9);
    $display("t_lit done");
  endtask

  task t_skip;
    fmem[8'h20] = 8'h05;
    put(0, {16'hb001, 16'h9920, 16'hb0aa, 16'hb011, 16'h9220, 16'hb0bb,
            16'h9a20, 16'hb022});
    boot(1'b0, 1'b0);
    ex(8'h01, 4'h0);
    ex(8'h01, 4'h0);
    check(16'(file_addr), 16'h0020);
    ex(8'h01, 4'h0);
    check(16'(skip_active), 16'h0001);
    ex(8'h11, 4'h0);
    ex(8'h11, 4'h0);
    ex(8'h11, 4'h0);
    ex(8'h11, 4'h0);
    ex(8'h22, 4'h0);
    check(16'(skip_active), 16'h0000);
    $display("t_skip done");
  endtask

  task t_cmp;
    fmem[8'h21] = 8'h40;
    put(0, {16'hb500, 16'hb040, 16'h3121, 16'hb001, 16'hb030, 16'h3221,
            16'hb002, 16'hb050});
    put(8, {16'h3221, 16'hb003, 96'h0});
    boot(1'b0, 1'b0);
    ex(8'h00, 4'h4);
    ex(8'h40, 4'h4);
    ex(8'h40, 4'h4);
    ex(8'h40, 4'h4);
    ex(8'h30, 4'h4);
    ex(8'h30, 4'h4);
    ex(8'h30, 4'h4);
    ex(8'h50, 4'h4);
    ex(8'h50, 4'h4);
    ex(8'h03, 4'h4);
    $display("t_cmp done");
  endtask

  task t_flow;
    put(0, {16'hb001, 16'hd010, 96'h0});
    put(16, {16'hb077, 16'he020, 16'hb033, 16'he030, 16'hb044, 16'hb740,
             32'h0});
    put(32, {16'hb65a, 112'h0});
    put(48, {16'h0002, 112'h0});
    put(64, {16'hb066, 112'h0});
    boot(1'b0, 1'b0);
    ex(8'h01, 4'h0);
    ex(8'h01, 4'h0);
    ex(8'h01, 4'h0);
    check(16'(pc_high_latch), 16'h0010);
    ex(8'h77, 4'h0);
    ex(8'h77, 4'h0);
    ex(8'h77, 4'h0);
    ex(8'h5a, 4'h0);
    ex(8'h5a, 4'h0);
    ex(8'h33, 4'h0);
    step(2);
    ex(8'h33, 4'h0);
    ex(8'h33, 4'h0);
    ex(8'h44, 4'h0);
    step(2);
    check(prog_addr, 16'h0040);
    ex(8'h66, 4'h0);
    $display("t_flow done");
  endtask

  task t_misc;
    fmem[8'h21] = 8'hf0;
    put(0, {16'hb8f5, 16'hba9f, 16'hb012, 16'hbc03, 16'hb0f0, 16'h0d21,
            16'h0004, 16'h0005});
    boot(1'b0, 1'b0);
    step(1);
    check(16'(bank_select_register), 16'h0005);
    step(1);
    check(16'(bank_select_register), 16'h0095);
    ex(8'h12, 4'h0);
    step(1);
    check(product, 16'h0036);
    ex(8'hf0, 4'h0);
    ex(8'hf0, 4'h4);
    check(16'({file_we, file_wdata}), 16'h0100);
    step(1);
    check(16'({timeout_status_bit, powerdown_status_bit}), 16'h3);
    step(1);
    check(16'(global_irq_disable_bit), 16'h0);
    $display("t_misc done");
  endtask

  task t_table;
    put(0, {16'hac20, 16'hb001, 16'h0000, 16'h0000, 16'h0000, 16'hb003,
            32'h0});
    boot(1'b0, 1'b0);
    ex(8'h00, 4'h0);
    ex(8'h00, 4'h0);
    ex(8'h01, 4'h0);
    boot(1'b1, 1'b0);
    repeat (5) ex(8'h00, 4'h0);
    @(posedge clk);
    irq_event <= 1'b1;
    for (int i = 0; i < 4 && working_register !== 8'h01; i++)
      step(1);
    check(16'(working_register), 16'h0001);
    mem[0] = 16'hc005;
    boot(1'b0, 1'b1);
    repeat (3) ex(8'h00, 4'h0);
    ex(8'h03, 4'h0);
    $display("t_table done");
  endtask

  // Main sequence
  initial
  begin
    foreach (mem[i]) mem[i] = OPW_NOP;
    foreach (fmem[i]) fmem[i] = BYTE_RESET;
    repeat (5) @(posedge clk);
    t_lit();
    t_skip();
    t_cmp();
    t_flow();
    t_misc();
    t_table();
    stop_test();
  end

  // Watchdog against a hang
  initial
  begin
    #100000;
    errors++;
    stop_test();
  end
endmodule
